// [hw/macrocell_pkg.sv]
// package: constants and types for the output macrocell array
package macrocell_pkg;

  localparam int NUM_CELLS       = 8;
  localparam int TERMS_PER_CELL  = 8;
  localparam int ARRAY_INPUTS    = 16;

  // register map (byte addresses)
  localparam logic [7:0] MODE_OFFSET     = 8'h00;
  localparam logic [7:0] CELLCFG_OFFSET  = 8'h04;
  localparam logic [7:0] PTERM_OFFSET    = 8'h08;
  localparam logic [7:0] STATUS_OFFSET   = 8'h0c;
  localparam logic [7:0] PINS_IN_OFFSET  = 8'h10;
  localparam logic [7:0] PD_CTRL_OFFSET  = 8'h14;

  // product-term memory: index = cell*8 + term, each word = one 16-bit mask of array inputs
  localparam int PTERM_ADDR_LSB  = 16;
  localparam int PTERM_ADDR_W    = 6;

  localparam logic [1:0]  MODE_RESET     = 2'h2;
  localparam logic [15:0] CELLCFG_RESET  = 16'h0000;
  localparam logic [7:0]  CELL_REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_REGISTERED = 2'b00,
    MODE_COMPLEX    = 2'b01,
    MODE_SIMPLE     = 2'b10
  } arch_mode_t;

  // per-cell role, two bits per macrocell
  typedef enum logic [1:0] {
    ROLE_INPUT      = 2'b00,
    ROLE_COMB       = 2'b01,
    ROLE_REGISTERED = 2'b10
  } cell_role_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_state_t;

endpackage

// [hw/pterm_mem.sv]
// product-term mask memory with registered read data
`timescale 1ns/1ns
module pterm_mem
  import macrocell_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int WIDTH = 32,
  parameter int AW    = 6
)
(
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0]   rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // elaboration-time guard: every address must name exactly one word
  if (DEPTH != (1 << AW))
  begin : g_bad_depth
    $error("pterm_mem depth must equal 2**AW");
  end

  // no reset: contents are loaded by software before use
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

// [hw/pld_output_macrocell_modes.sv]
// top: eight configurable output macrocells with an ahb-lite configuration port
//
// Notes on behaviour
// R1: registered mode: first pin is common clock, eleventh is common enable, not inputs.
// R2: registered cell updates on common clock, enabled by common pin, eight terms summed.
// R3: combinatorial cell in registered mode: one enable term, seven sum terms.
// R4: input-configured cell keeps its output driver off.
// R5: complex mode: clock/enable pins enter array via outer cells' feedback paths.
// R6: complex mode: six inner cells feed pins back; outer two are output only.
// R7: complex mode: seven sum terms plus one output-enable term per cell.
// R8: simple mode: eight sum terms; clock and enable pins are plain inputs.
// R9: simple mode: centre two cells always enabled combinatorial, no feedback.
// R10: simple mode: other cells input or comb output, feedback via adjacent pin.
// R11: configuring software picks the mode from register and enable usage.
// R12: with power-down enabled, the power-down pin is no array input.
// R13: at reset registers clear low, registered outputs present high.
// R14: during power-down outputs, enables and state hold; inputs ignored.
// R15: register captures sum on rising common clock; pin shows inverted value.
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module pld_output_macrocell_modes
  import macrocell_pkg::*;
#(
  parameter int NCELL = NUM_CELLS
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        clk_pin,
  input  wire logic        oe_n_pin,
  input  wire logic [7:0]  dedicated_in,
  input  wire logic [7:0]  io_in,
  output logic [7:0]       io_out,
  output logic [7:0]       io_oe
);

  localparam int PD_INPUT = 2;

  // elaboration-time guard: pin routing below is written for eight cells
  if (NCELL != 8)
  begin : g_bad_cells
    $error("macrocell array is fixed at eight cells");
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  arch_mode_t  mode_reg;
  logic [15:0] cellcfg_reg;
  logic        pd_enable_reg;
  logic        pd_pin_reg;
  logic [7:0]  cell_reg;
  logic        clk_pin_d_reg;
  bus_state_t  bus_state_reg;
  logic [7:0]  addr_reg;
  logic [31:0] rd_word_reg;

  logic        pt_wr_en;
  logic [5:0]  pt_rd_addr;
  logic [31:0] pt_rd_data;
  logic [5:0]  scan_reg;
  logic [63:0] pterm_reg;

  wire logic addr_phase = hsel && hready && htrans[1];

  // ------------------------------------------------------------------
  // ahb-lite slave: no wait states on reads or writes; hreadyout stays high
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state_reg <= BUS_IDLE;
      addr_reg      <= 8'h00;
    end
    else if (addr_phase)
    begin
      bus_state_reg <= hwrite ? BUS_WRITE : BUS_READ;
      addr_reg      <= haddr[7:0];
    end
    else if (hreadyout)
      bus_state_reg <= BUS_IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else
      hreadyout <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  wire logic wr_now = (bus_state_reg == BUS_WRITE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg      <= arch_mode_t'(MODE_RESET);
      cellcfg_reg   <= CELLCFG_RESET;
      pd_enable_reg <= 1'b0;
    end
    else if (wr_now)
    begin
      unique case (addr_reg)
        MODE_OFFSET:    mode_reg <= (hwdata[1:0] == 2'b11) ? mode_reg : arch_mode_t'(hwdata[1:0]);
        CELLCFG_OFFSET: cellcfg_reg <= hwdata[15:0];
        PD_CTRL_OFFSET: pd_enable_reg <= hwdata[0];
        default:        ;
      endcase
    end
  end

  // product-term words: address field selects cell*8+term
  assign pt_wr_en   = wr_now && (addr_reg == PTERM_OFFSET);
  assign pt_rd_addr = scan_reg;

  pterm_mem #(.DEPTH(64), .WIDTH(32), .AW(PTERM_ADDR_W)) u_pterm (
    .clk     (hclk),
    .wr_en   (pt_wr_en),
    .wr_addr (hwdata[PTERM_ADDR_LSB +: PTERM_ADDR_W]),
    .wr_data ({16'h0000, hwdata[15:0]}),
    .rd_addr (pt_rd_addr),
    .rd_data (pt_rd_data)
  );

  // ------------------------------------------------------------------
  // term scan: the memory is swept continuously into a flat term table;
  // this costs latency after a term write but keeps one read port
  // ------------------------------------------------------------------
  logic [5:0] scan_d_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scan_reg   <= 6'h00;
      scan_d_reg <= 6'h00;
    end
    else
    begin
      scan_reg   <= scan_reg + 6'h01;
      scan_d_reg <= scan_reg;
    end
  end

  logic [15:0] mask_tab [64];
  always_ff @(posedge hclk)
  begin
    mask_tab[scan_d_reg] <= pt_rd_data[15:0];
  end

  // ------------------------------------------------------------------
  // array inputs and feedback
  // ------------------------------------------------------------------
  logic [15:0] arr_in;
  logic [7:0]  fb;
  logic        pd_active;

  assign pd_active = pd_enable_reg && pd_pin_reg;

  always_comb
  begin
    arr_in = {dedicated_in, 8'h00};
    if (pd_enable_reg)
      arr_in[8 + PD_INPUT] = 1'b0; // R12
    unique case (mode_reg)
      MODE_REGISTERED:
      begin
        // pins 1 and 11 serve only as clock and enable
        arr_in[7:0] = fb; // R1
      end
      MODE_COMPLEX:
      begin
        arr_in[7:0] = {clk_pin, fb[6:1], oe_n_pin}; // R5 R6
      end
      default:
      begin
        // clock and enable pins use the slots left free beside the centre cells
        arr_in[7:0] = fb;
        arr_in[2]   = clk_pin; // R8
        arr_in[5]   = oe_n_pin; // R8
      end
    endcase
  end

  // ------------------------------------------------------------------
  // per-cell sum terms, enables and feedback
  // ------------------------------------------------------------------
  logic [7:0] sum8;
  logic [7:0] sum7;
  logic [7:0] pt_oe;
  logic [7:0] oe_next;
  logic [7:0] out_next;

  genvar c;
  generate
    for (c = 0; c < 8; c++)
    begin : g_cell
      logic [7:0] pt;
      cell_role_t role;
      assign role = cell_role_t'(cellcfg_reg[2*c +: 2]);
      for (genvar t = 0; t < 8; t++)
      begin : g_term
        // a term is the and of the array inputs its mask selects; empty mask is low
        assign pt[t] = (mask_tab[c*8+t] != 16'h0000) && ((arr_in & mask_tab[c*8+t]) == mask_tab[c*8+t]);
      end
      assign sum8[c]  = |pt; // R2 R8
      assign sum7[c]  = |pt[7:1]; // R3 R7
      assign pt_oe[c] = pt[0]; // R3 R7

      always_comb
      begin
        oe_next[c]  = 1'b0;
        out_next[c] = sum7[c];
        unique case (mode_reg)
          MODE_REGISTERED:
          begin
            if (role == ROLE_REGISTERED)
            begin
              out_next[c] = ~cell_reg[c]; // R15
              oe_next[c]  = ~oe_n_pin; // R2
            end
            else if (role == ROLE_COMB)
              oe_next[c] = pt_oe[c]; // R3
          end
          MODE_COMPLEX:
            oe_next[c] = (role != ROLE_INPUT) ? pt_oe[c] : 1'b0; // R7
          default:
          begin
            out_next[c] = sum8[c];
            if (c == 3 || c == 4)
              oe_next[c] = 1'b1; // R9
            else
              oe_next[c] = (role != ROLE_INPUT); // R10 R4
          end
        endcase
      end
    end
  endgenerate

  always_comb
  begin
    unique case (mode_reg)
      MODE_REGISTERED:
      begin
        for (int i = 0; i < 8; i++)
          fb[i] = (cell_role_t'(cellcfg_reg[2*i +: 2]) == ROLE_REGISTERED) ? cell_reg[i] : io_in[i];
      end
      MODE_COMPLEX:
        fb = io_in; // R6
      default:
      begin
        // paths other than 2 and 5 carry a neighbour's pin; centre pins never reach the array
        fb = {io_in[6], io_in[7], 1'b0, io_in[5], io_in[2], 1'b0, io_in[0], io_in[1]}; // R9 R10
      end
    endcase
  end

  // ------------------------------------------------------------------
  // common clock edge detection and macrocell registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_pin_d_reg <= 1'b0;
      pd_pin_reg    <= 1'b0;
    end
    else
    begin
      clk_pin_d_reg <= clk_pin;
      pd_pin_reg    <= dedicated_in[PD_INPUT];
    end
  end

  wire logic clk_rise = clk_pin && !clk_pin_d_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cell_reg <= CELL_REG_RESET; // R13
    else if (mode_reg == MODE_REGISTERED && clk_rise && !pd_active) // R14
    begin
      for (int i = 0; i < 8; i++)
        if (cell_role_t'(cellcfg_reg[2*i +: 2]) == ROLE_REGISTERED)
          cell_reg[i] <= sum8[i]; // R15 R2
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      io_out <= 8'hff; // R13
      io_oe  <= 8'h00;
    end
    else if (!pd_active) // R14
    begin
      io_out <= out_next;
      io_oe  <= oe_next; // R4
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        MODE_OFFSET:    hrdata <= {30'h0, mode_reg};
        CELLCFG_OFFSET: hrdata <= {16'h0, cellcfg_reg};
        STATUS_OFFSET:  hrdata <= {15'h0, pd_active, cell_reg, io_oe};
        PINS_IN_OFFSET: hrdata <= {16'h0, arr_in};
        PD_CTRL_OFFSET: hrdata <= {31'h0, pd_enable_reg};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_input_off;
    @(posedge hclk) disable iff (!hresetn)
    (mode_reg == MODE_COMPLEX && cellcfg_reg[1:0] == 2'b00 && !pd_active) |=> !io_oe[0];
  endproperty
  a_input_off: assert property (p_input_off) else $error("input cell drove its pin"); // R4

  property p_centre_on;
    @(posedge hclk) disable iff (!hresetn)
    (mode_reg == MODE_SIMPLE && !pd_active) |=> (io_oe[4:3] == 2'b11);
  endproperty
  a_centre_on: assert property (p_centre_on) else $error("centre cells not enabled"); // R9

  property p_pd_hold;
    @(posedge hclk) disable iff (!hresetn)
    pd_active |=> ($stable(io_out) && $stable(io_oe) && $stable(cell_reg));
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("state moved in power-down"); // R14

  property p_reg_inv;
    @(posedge hclk) disable iff (!hresetn)
    (mode_reg == MODE_REGISTERED && cellcfg_reg[1:0] == 2'b10 && !pd_active) |=> (io_out[0] == ~$past(cell_reg[0]));
  endproperty
  a_reg_inv: assert property (p_reg_inv) else $error("registered pin not inverted"); // R15

  property p_reg_oe;
    @(posedge hclk) disable iff (!hresetn)
    (mode_reg == MODE_REGISTERED && cellcfg_reg[1:0] == 2'b10 && !pd_active) |=> (io_oe[0] == !$past(oe_n_pin));
  endproperty
  a_reg_oe: assert property (p_reg_oe) else $error("common enable ignored"); // R2

  property p_no_clk_hold;
    @(posedge hclk) disable iff (!hresetn)
    !clk_rise |=> $stable(cell_reg);
  endproperty
  a_no_clk_hold: assert property (p_no_clk_hold) else $error("register moved without clock edge"); // R15

  property p_pd_input;
    @(posedge hclk) disable iff (!hresetn)
    pd_enable_reg |-> !arr_in[8 + PD_INPUT];
  endproperty
  a_pd_input: assert property (p_pd_input) else $error("power-down pin reached array"); // R12

  property p_reg_pins;
    @(posedge hclk) disable iff (!hresetn)
    (mode_reg == MODE_REGISTERED && $stable(mode_reg) && $stable(cellcfg_reg) && $stable(io_in) && $stable(cell_reg))
      |-> $stable(arr_in[7:0]);
  endproperty
  a_reg_pins: assert property (p_reg_pins) else $error("clock pin entered array"); // R1

  c_reg_clock:  cover property (@(posedge hclk) disable iff (!hresetn) clk_rise && mode_reg == MODE_REGISTERED);
  c_power_down: cover property (@(posedge hclk) disable iff (!hresetn) pd_active ##1 !pd_active);
  c_term_write: cover property (@(posedge hclk) disable iff (!hresetn) pt_wr_en);

endmodule

// [verification/pld_output_macrocell_modes_tb.sv]
// self-checking bench for the output macrocell array
`timescale 1ns/1ns
module pld_output_macrocell_modes_tb;
  import macrocell_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] exp;} row_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        clk_pin;
  logic        oe_n_pin;
  logic [7:0]  dedicated_in;
  logic [7:0]  io_in;
  logic [7:0]  io_out;
  logic [7:0]  io_oe;
  logic [7:0]  o_seen;
  int          bad_count;
  int          check_count;
  row_t        rows [8];

  // single slave: its hreadyout is the bus hready
  pld_output_macrocell_modes i_dut (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .clk_pin      (clk_pin),
    .oe_n_pin     (oe_n_pin),
    .dedicated_in (dedicated_in),
    .io_in        (io_in),
    .io_out       (io_out),
    .io_oe        (io_oe)
  );

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // bounded wait; a slave that never answers ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        bad_count++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk32(x & m, e);
  endtask

  task automatic term(input logic [5:0] idx, input logic [15:0] mask);
    wr(PTERM_OFFSET, {10'h0, idx, mask});
  endtask

  // cell 3 comb: term 0 enables on dedicated_in[1], term 7 sums dedicated_in[0]
  task automatic comb_chk(input logic [1:0] mode);
    wr(MODE_OFFSET, {30'h0, mode});
    wr(CELLCFG_OFFSET, 32'h0040);
    dedicated_in <= 8'h02;
    settle(3);
    o_seen = io_out;
    chk8(io_oe & 8'h08, 8'h08);
    dedicated_in <= 8'h03;
    settle(3);
    chk8(io_out & 8'h08, ~o_seen & 8'h08);
    dedicated_in <= 8'h00;
    settle(3);
    chk8(io_oe & 8'h08, 8'h00);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    test_done();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    clk_pin = 1'b0;
    oe_n_pin = 1'b0;
    dedicated_in = 8'h00;
    io_in = 8'h00;
    bad_count = 0;
    check_count = 0;
    rows = '{'{MODE_OFFSET, 32'h1, 32'h1}, '{MODE_OFFSET, 32'h3, 32'h1}, '{MODE_OFFSET, 32'h0, 32'h0},
             '{CELLCFG_OFFSET, 32'h2914, 32'h2914}, '{PTERM_OFFSET, 32'h0, 32'h0},
             '{8'h20, 32'hffff_ffff, 32'h0}, '{PD_CTRL_OFFSET, 32'h1, 32'h1}, '{PD_CTRL_OFFSET, 32'h0, 32'h0}};
    repeat (2) @(posedge hclk);
    chk8(io_out, 8'hff);
    chk8(io_oe, 8'h00);
    chk8({7'h00, hresp}, 8'h00);
    chk8({7'h00, hreadyout}, 8'h01);
    hresetn <= 1'b1;
    settle(1);
    // term memory has no reset, so clear it before use
    for (int i = 0; i < 64; i++)
      term(6'(i), 16'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].wd);
      rd_chk(rows[i].a, 32'hffff_ffff, rows[i].exp);
    end
    term(6'd0, 16'h0100);
    term(6'd24, 16'h0200);
    term(6'd31, 16'h0100);
    settle(70);
    wr(MODE_OFFSET, 32'h2);
    wr(CELLCFG_OFFSET, 32'h0);
    dedicated_in <= 8'h04;
    io_in <= 8'hbd;
    settle(3);
    chk8(io_oe, 8'h18);
    rd_chk(PINS_IN_OFFSET, 32'hffff, 32'h045a);
    wr(CELLCFG_OFFSET, 32'h5555);
    settle(3);
    chk8(io_oe, 8'hff);
    wr(MODE_OFFSET, 32'h1);
    wr(CELLCFG_OFFSET, 32'h0);
    dedicated_in <= 8'h00;
    io_in <= 8'hff;
    settle(3);
    rd_chk(PINS_IN_OFFSET, 32'hff, 32'h7e);
    io_in <= 8'h00;
    clk_pin <= 1'b1;
    oe_n_pin <= 1'b1;
    settle(3);
    rd_chk(PINS_IN_OFFSET, 32'hff, 32'h81);
    clk_pin <= 1'b0;
    oe_n_pin <= 1'b0;
    comb_chk(MODE_COMPLEX);
    comb_chk(MODE_REGISTERED);
    wr(CELLCFG_OFFSET, 32'h0002);
    clk_pin <= 1'b1;
    oe_n_pin <= 1'b1;
    settle(3);
    rd_chk(PINS_IN_OFFSET, 32'hfe, 32'h0);
    oe_n_pin <= 1'b0;
    clk_pin <= 1'b0;
    dedicated_in <= 8'h01;
    settle(3);
    chk8(io_out & 8'h01, 8'h01);
    clk_pin <= 1'b1;
    settle(3);
    chk8(io_out & 8'h01, 8'h00);
    chk8(io_oe & 8'h01, 8'h01);
    rd_chk(STATUS_OFFSET, 32'h100, 32'h100);
    oe_n_pin <= 1'b1;
    clk_pin <= 1'b0;
    dedicated_in <= 8'h00;
    settle(3);
    chk8(io_oe & 8'h01, 8'h00);
    chk8(io_out & 8'h01, 8'h00);
    oe_n_pin <= 1'b0;
    wr(PD_CTRL_OFFSET, 32'h1);
    dedicated_in <= 8'h04;
    settle(3);
    rd_chk(STATUS_OFFSET, 32'h1_0000, 32'h1_0000);
    rd_chk(PINS_IN_OFFSET, 32'h0400, 32'h0);
    clk_pin <= 1'b1;
    oe_n_pin <= 1'b1;
    settle(3);
    chk8(io_out & 8'h01, 8'h00);
    chk8(io_oe & 8'h01, 8'h01);
    clk_pin <= 1'b0;
    dedicated_in <= 8'h00;
    settle(3);
    chk8(io_oe & 8'h01, 8'h00);
    clk_pin <= 1'b1;
    settle(3);
    chk8(io_out & 8'h01, 8'h01);
    hresetn <= 1'b0;
    settle(2);
    chk8(io_out, 8'hff);
    chk8(io_oe, 8'h00);
    hresetn <= 1'b1;
    settle(1);
    rd_chk(STATUS_OFFSET, 32'hff00, 32'h0);
    test_done();
  end
endmodule
